// *** src/pmar_pkg.sv ***
// Constants and carrier types of the power profile and alarm register bank.
package pmar_pkg;

  // ==========================================================================
  // Widths and offsets
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ALM_W  = 6;

  localparam logic [11:0] OFS_PROFILE_SECOND = 12'h29A;
  localparam logic [11:0] OFS_PROFILE_THIRD  = 12'h29B;
  localparam logic [11:0] OFS_PROFILE_FOURTH = 12'h29C;
  localparam logic [11:0] OFS_ALARM_SUMMARY  = 12'h2C0;
  localparam logic [11:0] OFS_ALARM_STATUS   = 12'h2C1;
  localparam logic [11:0] OFS_ALARM_MASK     = 12'h2C2;

  // ==========================================================================
  // Profile codes and reset values
  localparam logic [7:0] CODE_SECOND_LOW  = 8'h06;
  localparam logic [7:0] CODE_SECOND_HIGH = 8'h0F;
  localparam logic [7:0] CODE_THIRD_LOW   = 8'h00;
  localparam logic [7:0] CODE_THIRD_HIGH  = 8'h04;
  localparam logic [7:0] CODE_FOURTH_LOW  = 8'h14;
  localparam logic [7:0] CODE_FOURTH_HIGH = 8'h1B;

  localparam logic [7:0] RST_ALARM_SUMMARY = 8'h00;
  localparam logic [7:0] RST_ALARM_FLAGS   = 8'h3F;
  localparam logic [7:0] READ_UNMAPPED     = 8'h00;
  localparam int unsigned SUMMARY_BIT      = 0;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pmar_req_type;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] rdata;
  } pmar_rsp_type;

endpackage

// *** src/pmar_alarm_unit.sv ***
// Alarm status flags, alarm mask bits and the summary alarm bit.
`timescale 1ns/10ps
module pmar_alarm_unit
  import pmar_pkg::*;
#(
  parameter int unsigned N = ALM_W
)(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [N-1:0]      alarm_event,
  input  wire logic              wr_status,
  input  wire logic              wr_mask,
  input  wire logic [DATA_W-1:0] wdata,
  output logic      [N-1:0]      status_q,
  output logic      [N-1:0]      mask_q,
  output logic                   summary_q
);

  // ==========================================================================
  // Parameter check
  if (N < 1 || N > DATA_W)
  begin : g_bad_n
    $error("Alarm count must lie between one and the data width.");
  end

  typedef struct packed {
    logic [N-1:0] status;
    logic [N-1:0] mask;
    logic         summary;
  } pmar_alarm_state_type;

  pmar_alarm_state_type st_r;
  pmar_alarm_state_type st_nxt;

  // ==========================================================================
  // Next state
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.status = (st_r.status & ~(wr_status ? wdata[N-1:0] : '0)) | alarm_event;
    if (wr_mask)
    begin
      st_nxt.mask = wdata[N-1:0];
    end
    st_nxt.summary = |(st_r.status & ~st_r.mask);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r.status  <= RST_ALARM_FLAGS[N-1:0];
      st_r.mask    <= RST_ALARM_FLAGS[N-1:0];
      st_r.summary <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign status_q  = st_r.status;
  assign mask_q    = st_r.mask;
  assign summary_q = st_r.summary;

  // ==========================================================================
  // Assertions
  a_summary_or_mask:
    assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> summary_q == $past(|(status_q & ~mask_q)))
    else $error("Summary bit does not follow unmasked status.");

  a_mask_blocks_all:
    assert property (@(posedge clk) disable iff (rst)
      ((status_q & ~mask_q) == '0) |=> !summary_q)
    else $error("Masked alarm reached the summary bit.");

  a_w1c_clears_flag:
    assert property (@(posedge clk) disable iff (rst)
      wr_status && wdata[0] && !alarm_event[0] |=> !status_q[0])
    else $error("Writing one did not clear the status flag.");

  a_event_sets_flag:
    assert property (@(posedge clk) disable iff (rst)
      alarm_event != '0 |=> (status_q & $past(alarm_event)) == $past(alarm_event))
    else $error("Alarm event was lost.");

  a_flags_stay_sticky:
    assert property (@(posedge clk) disable iff (rst)
      !wr_status |=> (status_q & $past(status_q)) == $past(status_q))
    else $error("Status flag fell without a clearing write.");

endmodule

// *** src/pmar_regs.sv ***
// Power profile registers and summary alarm logic behind the configuration port.
`timescale 1ns/10ps
module pmar_regs
  import pmar_pkg::*;
#(
  parameter int unsigned NUM_ALARMS = ALM_W
)(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire pmar_req_type          cfg_req,
  output pmar_rsp_type               cfg_rsp,
  input  wire logic [NUM_ALARMS-1:0] alarm_event,
  input  wire logic                  status_pin_sel,
  input  wire logic                  cal_status_src,
  output logic                       calibration_status_pin,
  output logic                       low_power_active,
  output logic                       high_perf_active,
  output logic [DATA_W-1:0]          profile_code_second,
  output logic [DATA_W-1:0]          profile_code_third,
  output logic [DATA_W-1:0]          profile_code_fourth
);

  // ==========================================================================
  // Parameter check
  if (NUM_ALARMS < 1 || NUM_ALARMS > DATA_W)
  begin : g_bad_alarms
    $error("Alarm count must lie between one and the data width.");
  end

  typedef struct packed {
    logic [DATA_W-1:0] prof_second;
    logic [DATA_W-1:0] prof_third;
    logic [DATA_W-1:0] prof_fourth;
    logic              low_active;
    logic              high_active;
    logic              pin;
    pmar_rsp_type      rsp;
  } pmar_regs_state_type;

  pmar_regs_state_type st_r;
  pmar_regs_state_type st_nxt;

  logic                  wr_hit;
  logic                  rd_hit;
  logic                  wr_status;
  logic                  wr_mask;
  logic [NUM_ALARMS-1:0] status_q;
  logic [NUM_ALARMS-1:0] mask_q;
  logic                  summary_q;
  logic [DATA_W-1:0]     rd_data;

  // ==========================================================================
  // Decode
  assign wr_hit    = cfg_req.valid && cfg_req.write;
  assign rd_hit    = cfg_req.valid && !cfg_req.write;
  assign wr_status = wr_hit && (cfg_req.addr == OFS_ALARM_STATUS);
  assign wr_mask   = wr_hit && (cfg_req.addr == OFS_ALARM_MASK);

  // ==========================================================================
  // Alarm flags
  pmar_alarm_unit #(
    .N           (NUM_ALARMS)
  ) u_alarm (
    .clk         (clk),
    .rst         (rst),
    .alarm_event (alarm_event),
    .wr_status   (wr_status),
    .wr_mask     (wr_mask),
    .wdata       (cfg_req.wdata),
    .status_q    (status_q),
    .mask_q      (mask_q),
    .summary_q   (summary_q)
  );

  // ==========================================================================
  // Read multiplexer
  always_comb
  begin
    rd_data = READ_UNMAPPED;
    case (cfg_req.addr)
      OFS_PROFILE_SECOND: rd_data = st_r.prof_second;
      OFS_PROFILE_THIRD:  rd_data = st_r.prof_third;
      OFS_PROFILE_FOURTH: rd_data = st_r.prof_fourth;
      OFS_ALARM_SUMMARY:  rd_data[SUMMARY_BIT] = summary_q;
      OFS_ALARM_STATUS:   rd_data[NUM_ALARMS-1:0] = status_q;
      OFS_ALARM_MASK:     rd_data[NUM_ALARMS-1:0] = mask_q;
      default:            rd_data = READ_UNMAPPED;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb
  begin
    st_nxt = st_r;
    if (wr_hit)
    begin
      case (cfg_req.addr)
        OFS_PROFILE_SECOND: st_nxt.prof_second = cfg_req.wdata;
        OFS_PROFILE_THIRD:  st_nxt.prof_third  = cfg_req.wdata;
        OFS_PROFILE_FOURTH: st_nxt.prof_fourth = cfg_req.wdata;
        default:            st_nxt.prof_second = st_r.prof_second;
      endcase
    end
    st_nxt.low_active = (st_r.prof_second == CODE_SECOND_LOW)
                     && (st_r.prof_third  == CODE_THIRD_LOW)
                     && (st_r.prof_fourth == CODE_FOURTH_LOW);
    st_nxt.high_active = (st_r.prof_second == CODE_SECOND_HIGH)
                      && (st_r.prof_third  == CODE_THIRD_HIGH)
                      && (st_r.prof_fourth == CODE_FOURTH_HIGH);
    st_nxt.pin       = status_pin_sel ? summary_q : cal_status_src;
    st_nxt.rsp.valid = rd_hit;
    st_nxt.rsp.rdata = rd_hit ? rd_data : READ_UNMAPPED;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r.prof_second <= CODE_SECOND_HIGH;
      st_r.prof_third  <= CODE_THIRD_HIGH;
      st_r.prof_fourth <= CODE_FOURTH_HIGH;
      st_r.low_active  <= 1'b0;
      st_r.high_active <= 1'b1;
      st_r.pin         <= 1'b0;
      st_r.rsp         <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign cfg_rsp                = st_r.rsp;
  assign calibration_status_pin = st_r.pin;
  assign low_power_active       = st_r.low_active;
  assign high_perf_active       = st_r.high_active;
  assign profile_code_second    = st_r.prof_second;
  assign profile_code_third     = st_r.prof_third;
  assign profile_code_fourth    = st_r.prof_fourth;

  // ==========================================================================
  // Assertions
  a_reset_high_codes:
    assert property (@(posedge clk) disable iff (rst)
      $fell(rst) |-> profile_code_second == CODE_SECOND_HIGH
        && profile_code_third == CODE_THIRD_HIGH && profile_code_fourth == CODE_FOURTH_HIGH)
    else $error("Profile registers did not reset to high-performance codes.");

  a_low_profile_seen:
    assert property (@(posedge clk) disable iff (rst)
      profile_code_second == CODE_SECOND_LOW && profile_code_third == CODE_THIRD_LOW
        && profile_code_fourth == CODE_FOURTH_LOW |=> low_power_active && !high_perf_active)
    else $error("Low-power codes did not select the low-power profile.");

  a_high_profile_seen:
    assert property (@(posedge clk) disable iff (rst)
      profile_code_second == CODE_SECOND_HIGH && profile_code_third == CODE_THIRD_HIGH
        && profile_code_fourth == CODE_FOURTH_HIGH |=> high_perf_active && !low_power_active)
    else $error("High-performance codes did not select that profile.");

  a_second_code_gate:
    assert property (@(posedge clk) disable iff (rst)
      (profile_code_second != CODE_SECOND_LOW |=> !low_power_active)
        and (profile_code_second != CODE_SECOND_HIGH |=> !high_perf_active))
    else $error("Second code outside its profile selected that profile.");

  a_third_code_gate:
    assert property (@(posedge clk) disable iff (rst)
      (profile_code_third != CODE_THIRD_LOW |=> !low_power_active)
        and (profile_code_third != CODE_THIRD_HIGH |=> !high_perf_active))
    else $error("Third code outside its profile selected that profile.");

  a_fourth_code_gate:
    assert property (@(posedge clk) disable iff (rst)
      (profile_code_fourth != CODE_FOURTH_LOW |=> !low_power_active)
        and (profile_code_fourth != CODE_FOURTH_HIGH |=> !high_perf_active))
    else $error("Fourth code outside its profile selected that profile.");

  a_pin_routes_source:
    assert property (@(posedge clk) disable iff (rst)
      !status_pin_sel |=> calibration_status_pin == $past(cal_status_src))
    else $error("Status pin does not carry the calibration status value.");

  a_summary_write_ignored:
    assert property (@(posedge clk) disable iff (rst)
      wr_hit && cfg_req.addr == OFS_ALARM_SUMMARY
        |=> profile_code_second == $past(profile_code_second) && profile_code_third == $past(profile_code_third)
        && profile_code_fourth == $past(profile_code_fourth) && mask_q == $past(mask_q))
    else $error("Write to the summary register changed other state.");

  a_mask_reads_back:
    assert property (@(posedge clk) disable iff (rst)
      rd_hit && cfg_req.addr == OFS_ALARM_MASK |=> cfg_rsp.rdata == DATA_W'($past(mask_q)))
    else $error("Mask register read returned a wrong value.");

  a_pin_routes_alarm:
    assert property (@(posedge clk) disable iff (rst)
      status_pin_sel |=> calibration_status_pin == $past(summary_q))
    else $error("Status pin does not carry the summary alarm.");

  a_summary_read_only:
    assert property (@(posedge clk) disable iff (rst)
      rd_hit && cfg_req.addr == OFS_ALARM_SUMMARY
        |=> cfg_rsp.valid && cfg_rsp.rdata[7:1] == 7'h00 && cfg_rsp.rdata[0] == $past(summary_q))
    else $error("Summary register read returned a wrong value.");

  a_summary_from_flags:
    assert property (@(posedge clk) disable iff (rst)
      (status_q & ~mask_q) != '0 ##1 (status_q & ~mask_q) != '0 |-> summary_q)
    else $error("Unmasked alarm did not raise the summary bit.");

  c_enter_low_power:
    cover property (@(posedge clk) disable iff (rst) $rose(low_power_active));
  c_alarm_on_pin:
    cover property (@(posedge clk) disable iff (rst) status_pin_sel && $rose(calibration_status_pin));
  c_status_cleared:
    cover property (@(posedge clk) disable iff (rst) wr_status ##1 status_q == '0);
  c_return_high_perf:
    cover property (@(posedge clk) disable iff (rst) $rose(high_perf_active));
  c_alarm_masked_away:
    cover property (@(posedge clk) disable iff (rst) $fell(summary_q));

endmodule

// *** sim/testbench.sv ***
// Self-checking testbench for the power profile and alarm register bank.
`timescale 1ns/10ps
module testbench;
  import pmar_pkg::*;

  typedef struct packed {
    logic [7:0] second;
    logic [7:0] third;
    logic [7:0] fourth;
    logic       low;
    logic       high;
  } pmar_row_type;

  logic         clk = 1'b0;
  logic         rst;
  pmar_req_type cfg_req;
  pmar_rsp_type cfg_rsp;
  logic [5:0]   alarm_event;
  logic         status_pin_sel;
  logic         cal_status_src;
  logic         calibration_status_pin;
  logic         low_power_active;
  logic         high_perf_active;
  logic [7:0]   profile_code_second;
  logic [7:0]   profile_code_third;
  logic [7:0]   profile_code_fourth;
  int           failures;
  int           checks_done;

  pmar_row_type rows [8] = '{
    '{CODE_SECOND_LOW,  CODE_THIRD_LOW,  CODE_FOURTH_LOW,  1'b1, 1'b0},
    '{CODE_SECOND_HIGH, CODE_THIRD_HIGH, CODE_FOURTH_HIGH, 1'b0, 1'b1},
    '{CODE_SECOND_LOW,  CODE_THIRD_LOW,  CODE_FOURTH_LOW,  1'b1, 1'b0},
    '{CODE_SECOND_HIGH, CODE_THIRD_HIGH, CODE_FOURTH_HIGH, 1'b0, 1'b1},
    '{CODE_SECOND_LOW,  CODE_THIRD_LOW,  CODE_FOURTH_LOW,  1'b1, 1'b0},
    '{CODE_SECOND_HIGH, CODE_THIRD_HIGH, CODE_FOURTH_HIGH, 1'b0, 1'b1},
    '{CODE_SECOND_LOW,  CODE_THIRD_LOW,  CODE_FOURTH_LOW,  1'b1, 1'b0},
    '{CODE_SECOND_HIGH, CODE_THIRD_HIGH, CODE_FOURTH_HIGH, 1'b0, 1'b1}
  };

  // ==========================================================================
  // Clock and design
  always #2.5 clk = ~clk;

  pmar_regs #(.NUM_ALARMS(6)) dut (
    .clk                    (clk),
    .rst                    (rst),
    .cfg_req                (cfg_req),
    .cfg_rsp                (cfg_rsp),
    .alarm_event            (alarm_event),
    .status_pin_sel         (status_pin_sel),
    .cal_status_src         (cal_status_src),
    .calibration_status_pin (calibration_status_pin),
    .low_power_active       (low_power_active),
    .high_perf_active       (high_perf_active),
    .profile_code_second    (profile_code_second),
    .profile_code_third     (profile_code_third),
    .profile_code_fourth    (profile_code_fourth)
  );

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk) cfg_req <= {1'b1, 1'b1, a, d};
    @(posedge clk) cfg_req <= '0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk) cfg_req <= {1'b1, 1'b0, a, 8'h00};
    @(posedge clk) cfg_req <= '0;
    #1;
    chk({7'h00, cfg_rsp.valid}, 8'h01);
    chk(cfg_rsp.rdata, exp);
  endtask

  task automatic pulse(input logic [5:0] ev);
    @(posedge clk) alarm_event <= ev;
    @(posedge clk) alarm_event <= '0;
  endtask

  task automatic check_reset_state();
    chk(profile_code_second, CODE_SECOND_HIGH);
    chk(profile_code_third, CODE_THIRD_HIGH);
    chk(profile_code_fourth, CODE_FOURTH_HIGH);
    chk({6'h00, low_power_active, high_perf_active}, 8'h01);
    chk({7'h00, calibration_status_pin}, 8'h00);
  endtask

  task automatic complete_run();
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    complete_run();
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    rst = 1'b1;
    cfg_req = '0;
    alarm_event = '0;
    status_pin_sel = 1'b0;
    cal_status_src = 1'b0;
    repeat (15) @(posedge clk);
    #1;
    check_reset_state();
    @(posedge clk) rst <= 1'b0;
    #1;
    check_reset_state();
    rd(OFS_ALARM_SUMMARY, RST_ALARM_SUMMARY);
    rd(OFS_ALARM_STATUS, RST_ALARM_FLAGS);
    rd(OFS_ALARM_MASK, RST_ALARM_FLAGS);
    // Profile table: write all three registers, flags low after the write to the second register, then check flags and read back second and fourth.
    for (int i = 0; i < 8; i++)
    begin
      if (i[1])
        wr(OFS_PROFILE_FOURTH, rows[i].fourth);
      wr(OFS_PROFILE_SECOND, rows[i].second);
      @(posedge clk);
      #1;
      chk({6'h00, low_power_active, high_perf_active}, 8'h00);
      wr(OFS_PROFILE_THIRD, rows[i].third);
      if (!i[1])
        wr(OFS_PROFILE_FOURTH, rows[i].fourth);
      @(posedge clk);
      #1;
      chk({6'h00, low_power_active, high_perf_active}, {6'h00, rows[i].low, rows[i].high});
      chk(profile_code_second, rows[i].second);
      chk(profile_code_third, rows[i].third);
      chk(profile_code_fourth, rows[i].fourth);
      rd(OFS_PROFILE_SECOND, rows[i].second);
      rd(OFS_PROFILE_FOURTH, rows[i].fourth);
    end
    // Unmask all with every flag still set from reset.
    wr(OFS_ALARM_MASK, 8'h00);
    rd(OFS_ALARM_SUMMARY, 8'h01);
    @(posedge clk) status_pin_sel <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({7'h00, calibration_status_pin}, 8'h01);
    wr(OFS_ALARM_SUMMARY, 8'hFF);
    rd(OFS_ALARM_SUMMARY, 8'h01);
    rd(12'h123, READ_UNMAPPED);
    wr(OFS_ALARM_STATUS, 8'h3F);
    rd(OFS_ALARM_STATUS, 8'h00);
    rd(OFS_ALARM_SUMMARY, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    chk({7'h00, calibration_status_pin}, 8'h00);
    // Partial clear leaves the other flag standing.
    pulse(6'h21);
    wr(OFS_ALARM_STATUS, 8'h01);
    rd(OFS_ALARM_STATUS, 8'h20);
    // Each mask bit blocks only its own flag.
    for (int i = 0; i < 6; i++)
    begin
      wr(OFS_ALARM_STATUS, 8'h3F);
      pulse(6'(1 << i));
      wr(OFS_ALARM_MASK, 8'h3F & ~(8'h01 << i));
      rd(OFS_ALARM_SUMMARY, 8'h01);
      wr(OFS_ALARM_MASK, 8'h01 << i);
      rd(OFS_ALARM_SUMMARY, 8'h00);
      rd(OFS_ALARM_STATUS, 8'h01 << i);
    end
    // Selector low routes the calibration status value.
    @(posedge clk)
    begin
      status_pin_sel <= 1'b0;
      cal_status_src <= 1'b1;
    end
    repeat (2) @(posedge clk);
    #1;
    chk({7'h00, calibration_status_pin}, 8'h01);
    // Reset in mid-run restores the high-performance codes.
    wr(OFS_PROFILE_SECOND, CODE_SECOND_LOW);
    wr(OFS_PROFILE_THIRD, CODE_THIRD_LOW);
    wr(OFS_PROFILE_FOURTH, CODE_FOURTH_LOW);
    @(posedge clk) rst <= 1'b1;
    @(posedge clk);
    #1;
    check_reset_state();
    @(posedge clk) rst <= 1'b0;
    rd(OFS_ALARM_MASK, RST_ALARM_FLAGS);
    rd(OFS_PROFILE_THIRD, CODE_THIRD_HIGH);
    complete_run();
  end
endmodule
